// file: design/upi_pkg.sv
package upi_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_POWER_CONTROL     = 32'h15200144;
   localparam logic [31:0] ADDR_INTERRUPT_PENDING = 32'h15200148;
   localparam logic [31:0] ADDR_INTERRUPT_MASK    = 32'h1520014C;
   localparam logic [31:0] ADDR_RESUME_LENGTH     = 32'h15200154;
   // ------------------------------------------------------------
   // Power control fields
   // ------------------------------------------------------------
   localparam int PWR_CLK_GATE  = 8;
   localparam int PWR_SW_RESET  = 7;
   localparam int PWR_FLUSH     = 6;
   localparam int PWR_VBUS      = 5;
   localparam int PWR_BUS_RESET = 3;
   localparam int PWR_WAKE      = 2;
   localparam int PWR_SUSPENDED = 1;
   localparam int PWR_SUSP_EN   = 0;
   // ------------------------------------------------------------
   // Interrupt fields
   // ------------------------------------------------------------
   localparam int INT_ERROR   = 8;
   localparam int INT_RESET   = 7;
   localparam int INT_RESUME  = 6;
   localparam int INT_SUSPEND = 5;
   localparam int INT_EP4     = 4;
   localparam int INT_EP3     = 3;
   localparam int INT_EP2     = 2;
   localparam int INT_EP1     = 1;
   localparam int INT_EP0     = 0;
   localparam int MASK_CRC    = 9;
   localparam int MASK_STUFF  = 8;
   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [31:0] RST_POWER_CONTROL = 32'h00000000;
   localparam logic [9:0]  RST_MASK          = 10'h33F;
   localparam logic [4:0]  RST_RESUME_LENGTH = 5'h0A;
   localparam int CLK_MHZ         = 200;
   localparam int MS_NS           = 1000000;
   localparam int CLK_PERIOD_NS   = 5;
   localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
   localparam int IDLE_SUSPEND_MS = 3;

   // Per-endpoint event flags from the endpoint logic
   typedef struct packed {
      logic rxWaitingSet;
      logic txLoadedClear;
      logic stallDoneSet;
      logic fifoFlushed;
      logic setupEndSet;
      logic lastDataClear;
   } upi_ep_evt_t;

   typedef struct packed {
      logic crcError;
      logic stuffError;
      logic busReset;
      logic busResume;
      logic busActive;
   } upi_bus_t;
endpackage : upi_pkg

// file: design/upi_power_interrupt.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
module upi_power_interrupt
   import upi_pkg::*;
#(
   parameter int MS_COUNT = MS_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Register port
   input  wire logic [31:0]          regAddr,
   input  wire logic [31:0]          regWdata,
   input  wire logic                 regWr,
   input  wire logic                 regRd,
   output logic      [31:0]          regRdata,
   // Bus events (pins, asynchronous)
   input  wire upi_pkg::upi_bus_t    busIn,
   input  wire logic                 vbusIn,
   // Endpoint events, same clock
   input  wire upi_pkg::upi_ep_evt_t epEvt [5],
   // Control outputs
   output logic                      clkGate,
   output logic                      funcReset,
   output logic                      ctrlFifoFlush,
   output logic                      resumeDrive,
   output logic                      irq
);
   import upi_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   upi_bus_t busMeta;
   upi_bus_t bus;
   logic     vbusMeta;
   logic     vbus;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busMeta  <= '0;
         bus      <= '0;
         vbusMeta <= 1'b0;
         vbus     <= 1'b0;
      end else begin
         busMeta  <= busIn;
         bus      <= busMeta;
         vbusMeta <= vbusIn;
         vbus     <= vbusMeta;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire selPwr  = regAddr == ADDR_POWER_CONTROL;
   wire selInt  = regAddr == ADDR_INTERRUPT_PENDING;
   wire selMask = regAddr == ADDR_INTERRUPT_MASK;
   wire selRes  = regAddr == ADDR_RESUME_LENGTH;
   wire wrPwr   = regWr && selPwr;
   wire wrInt   = regWr && selInt;
   wire wrMask  = regWr && selMask;
   wire wrRes   = regWr && selRes;

   // ------------------------------------------------------------
   // Power control
   // ------------------------------------------------------------
   logic       suspEn;
   logic       suspended;
   logic       wake;
   logic [4:0] resumeLength;
   logic [9:0] intMask;
   logic [8:0] pending;
   logic [31:0] msCnt;
   logic [4:0]  resMs;
   logic [1:0]  idleMs;
   logic [31:0] idleCnt;
   logic        busResetQ;

   wire swResetWr   = wrPwr && regWdata[PWR_SW_RESET];
   wire msTick      = resumeDrive && (msCnt == 32'(MS_COUNT - 1));
   wire resumeDone  = msTick && (resMs == 5'h01);
   wire idle3ms     = (idleCnt == 32'(MS_COUNT - 1)) && (idleMs == 2'(IDLE_SUSPEND_MS - 1));
   wire busResume   = suspended && (bus.busResume || bus.busReset);
   wire wakeStart   = wrPwr && regWdata[PWR_WAKE] && suspended && !resumeDrive;
   wire suspendHit  = idle3ms && !suspended && suspEn && !resumeDrive;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkGate       <= 1'b0;
         funcReset     <= 1'b0;
         ctrlFifoFlush <= 1'b0;
         suspEn        <= 1'b0;
      end else if (wrPwr) begin
         // Gate may be set directly, but only a reset write removes it
         clkGate       <= regWdata[PWR_SW_RESET] ? 1'b0 :
                          (clkGate | regWdata[PWR_CLK_GATE]);
         funcReset     <= regWdata[PWR_SW_RESET];
         ctrlFifoFlush <= regWdata[PWR_FLUSH];
         suspEn        <= regWdata[PWR_SUSP_EN];
      end else begin
         ctrlFifoFlush <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         suspended <= 1'b0;
      end else if (busResume || wakeStart) begin
         suspended <= 1'b0;
      end else if (suspendHit) begin
         suspended <= 1'b1;
      end
   end

   // Resume length register; a write of zero is ignored since it cannot be used
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resumeLength <= RST_RESUME_LENGTH;
      end else if (wrRes && regWdata[4:0] != 5'h00) begin
         resumeLength <= regWdata[4:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake        <= 1'b0;
         resumeDrive <= 1'b0;
         msCnt       <= '0;
         resMs       <= '0;
      end else if (wakeStart) begin
         wake        <= 1'b1;
         resumeDrive <= 1'b1;
         msCnt       <= '0;
         resMs       <= resumeLength;
      end else if (resumeDone) begin
         wake        <= 1'b0;
         resumeDrive <= 1'b0;
      end else if (resumeDrive) begin
         msCnt <= msTick ? '0 : msCnt + 32'd1;
         resMs <= msTick ? resMs - 5'h01 : resMs;
      end
   end

   // Idle timer restarts on bus activity, our own resume included; fires every 3 ms
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idleCnt <= '0;
         idleMs  <= '0;
      end else if (bus.busActive || clkGate || resumeDrive) begin
         idleCnt <= '0;
         idleMs  <= '0;
      end else if (idleCnt == 32'(MS_COUNT - 1)) begin
         idleCnt <= '0;
         idleMs  <= idle3ms ? 2'h0 : idleMs + 2'h1;
      end else begin
         idleCnt <= idleCnt + 32'd1;
      end
   end

   // ------------------------------------------------------------
   // Interrupt pending and mask
   // ------------------------------------------------------------
   logic [8:0] setEvt;
   always_comb begin
      setEvt              = '0;
      setEvt[INT_ERROR]   = (bus.crcError && !intMask[MASK_CRC]) ||
                            (bus.stuffError && !intMask[MASK_STUFF]);
      setEvt[INT_RESET]   = (bus.busReset && !busResetQ) || swResetWr;
      setEvt[INT_RESUME]  = busResume;
      setEvt[INT_SUSPEND] = idle3ms;
      setEvt[INT_EP0]     = epEvt[0].rxWaitingSet || epEvt[0].txLoadedClear ||
                            epEvt[0].stallDoneSet || epEvt[0].setupEndSet ||
                            epEvt[0].lastDataClear;
      setEvt[INT_EP1]     = epEvt[1].txLoadedClear || epEvt[1].fifoFlushed;
      setEvt[INT_EP2]     = epEvt[2].txLoadedClear || epEvt[2].fifoFlushed;
      setEvt[INT_EP3]     = epEvt[3].rxWaitingSet || epEvt[3].stallDoneSet;
      setEvt[INT_EP4]     = epEvt[4].rxWaitingSet || epEvt[4].stallDoneSet;
   end

   wire [8:0] clrMask = wrInt ? regWdata[8:0] : 9'h000;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending   <= '0;
         busResetQ <= 1'b0;
      end else begin
         // A new event wins over a clear in the same cycle
         pending   <= (pending & ~clrMask) | setEvt;
         busResetQ <= bus.busReset;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         intMask <= RST_MASK;
      end else if (wrMask) begin
         intMask <= regWdata[9:0];
      end
   end

   // Resume is never maskable; error uses its own mask bits at the source
   wire [8:0] gate = {1'b0, intMask[INT_RESET], 1'b0, intMask[5:0]};
   wire       nextIrq = |(pending & ~gate);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= nextIrq;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   wire [31:0] pwrView = {23'h000000, clkGate, 1'b0, ctrlFifoFlush, vbus, 1'b0,
                          bus.busReset, wake, suspended, suspEn};
   wire [31:0] next_rdata = selPwr  ? pwrView :
                            selInt  ? {23'h000000, pending} :
                            selMask ? {22'h000000, intMask} :
                            selRes  ? {27'h0000000, resumeLength} : 32'h00000000;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         regRdata <= next_rdata;
      end else begin
         regRdata <= 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence sWake;
      wakeStart;
   endsequence
   sequence sDrive;
      resumeDrive [*8];
   endsequence

   a_gate_clear_only: assert property ($fell(clkGate) |-> $past(swResetWr))
      else $error("clock gate cleared without reset write");
   a_gate_set_write: assert property (wrPwr && regWdata[PWR_CLK_GATE] && !regWdata[PWR_SW_RESET]
      |=> clkGate)
      else $error("clock gate not set");
   a_reset_follows: assert property (wrPwr |=> funcReset == $past(regWdata[PWR_SW_RESET]))
      else $error("function reset wrong");
   a_wake_drives: assert property (sWake |=> sDrive)
      else $error("resume drive too short");
   a_susp_enable: assert property ($rose(suspended) |-> $past(suspEn))
      else $error("suspend entered while disabled");
   a_pend_clear: assert property (wrInt && regWdata[INT_EP0] && !setEvt[INT_EP0]
      |=> !pending[INT_EP0])
      else $error("pending bit not cleared");
   a_pend_hold: assert property (pending[INT_EP1] && !wrInt |=> pending[INT_EP1])
      else $error("pending bit lost");
   a_reset_pend: assert property (swResetWr |=> pending[INT_RESET])
      else $error("reset pending missing");
   a_resume_pend: assert property (busResume |=> pending[INT_RESUME] && !suspended)
      else $error("resume not flagged");
   a_irq_level: assert property (pending == 9'h000 |=> !irq)
      else $error("irq high with nothing pending");
   a_wake_clear: assert property (resumeDone |=> !wake && !resumeDrive)
      else $error("wake bit not cleared");

   // ------------------------------------------------------------
   // Resume burst length
   // ------------------------------------------------------------
   // Counted apart from the resume counter, so a slip there shows up here
   logic [31:0] driveCnt;
   logic [4:0]  driveLen;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         driveCnt <= 32'h00000000;
         driveLen <= 5'h00;
      end else if (wakeStart) begin
         driveCnt <= 32'h00000001;
         driveLen <= resumeLength;
      end else if (resumeDrive) begin
         driveCnt <= driveCnt + 32'h00000001;
      end
   end

   sequence sFlushWrite;
      wrPwr && regWdata[PWR_FLUSH];
   endsequence
   sequence sResumeStart;
      $rose(resumeDrive);
   endsequence

   a_flush_pulse: assert property (sFlushWrite |=> ctrlFifoFlush)
      else $error("control fifo flush missing");
   a_flush_idle: assert property (!wrPwr |=> !ctrlFifoFlush)
      else $error("control fifo flush too long");
   a_wake_suspended: assert property (sResumeStart |-> $past(suspended))
      else $error("resume driven while not suspended");
   a_drive_length: assert property (resumeDone
      |-> driveCnt == 32'(MS_COUNT) * {27'h0000000, driveLen})
      else $error("resume burst length wrong");
   a_len_zero_kept: assert property (wrRes && regWdata[4:0] == 5'h00
      |=> $stable(resumeLength))
      else $error("resume length took zero");
   a_susp_not_driving: assert property (resumeDrive |-> !suspended)
      else $error("suspended while driving resume");
   a_susp_entry: assert property (suspendHit |=> suspended)
      else $error("suspend not entered");
   a_err_pend: assert property (bus.crcError && !intMask[MASK_CRC]
      |=> pending[INT_ERROR])
      else $error("error pending missing");
   a_bus_reset_pend: assert property ($rose(bus.busReset)
      |=> pending[INT_RESET])
      else $error("bus reset pending missing");
   a_susp_pend: assert property (idle3ms |=> pending[INT_SUSPEND])
      else $error("suspend pending missing");
   a_susp_masked: assert property (pending == 9'h020 && intMask[INT_SUSPEND]
      |=> !irq)
      else $error("masked suspend raised irq");
   a_ep0_pend: assert property (epEvt[0].setupEndSet |=> pending[INT_EP0])
      else $error("endpoint 0 pending missing");
   a_ep1_pend: assert property (epEvt[1].fifoFlushed |=> pending[INT_EP1])
      else $error("endpoint 1 pending missing");
   a_ep3_pend: assert property (epEvt[3].stallDoneSet |=> pending[INT_EP3])
      else $error("endpoint 3 pending missing");
   a_resume_unmasked: assert property (pending[INT_RESUME] |=> irq)
      else $error("resume pending did not raise irq");
endmodule : upi_power_interrupt

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import upi_pkg::*;
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
      logic [31:0] data;
   } upi_row_t;
   // ------------------------------------------------------------
   // Signals and rows
   // ------------------------------------------------------------
   logic        clk, nrst, regWr, regRd, vbusIn;
   logic        clkGate, funcReset, ctrlFifoFlush, resumeDrive, irq;
   logic [31:0] regAddr, regWdata, regRdata, got;
   upi_bus_t    busIn;
   upi_ep_evt_t epEvt [5];
   int          errorCnt, cmpCount, cycles, n;
   logic [5:0]  evMask [5] = '{6'h3B, 6'h14, 6'h14, 6'h28, 6'h28};
   upi_row_t    rows [12] = '{
      '{1'b0, ADDR_POWER_CONTROL, 32'h00000020},
      '{1'b0, ADDR_INTERRUPT_PENDING, 32'h00000000},
      '{1'b0, ADDR_INTERRUPT_MASK, 32'h0000033F},
      '{1'b0, ADDR_RESUME_LENGTH, 32'h0000000A},
      '{1'b1, ADDR_RESUME_LENGTH, 32'h00000000},
      '{1'b0, ADDR_RESUME_LENGTH, 32'h0000000A},
      '{1'b1, ADDR_RESUME_LENGTH, 32'h00000003},
      '{1'b0, ADDR_RESUME_LENGTH, 32'h00000003},
      '{1'b1, ADDR_INTERRUPT_MASK, 32'h00000000},
      '{1'b1, 32'h15200158, 32'hFFFFFFFF},
      '{1'b0, 32'h15200158, 32'h00000000},
      '{1'b0, ADDR_INTERRUPT_MASK, 32'h00000000}};
   upi_power_interrupt #(.MS_COUNT(10)) uut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .busIn(busIn),
      .vbusIn(vbusIn), .epEvt(epEvt), .clkGate(clkGate), .funcReset(funcReset),
      .ctrlFifoFlush(ctrlFifoFlush), .resumeDrive(resumeDrive), .irq(irq));
   upi_host_model host (.clk(clk), .resumeDrive(resumeDrive), .busIn(busIn), .vbusIn(vbusIn));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errorCnt++;
         printVerdict();
      end
   end
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      cmpCount++;
      if (g !== e) begin
         errorCnt++;
         $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1; regAddr <= a; regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      check(regRdata & m, e);
   endtask : rd
   task automatic printVerdict();
      $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : printVerdict
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = '0; regWdata = '0;
      foreach (epEvt[i]) epEvt[i] = '0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      // Let the pin synchronisers fill before the first read
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         else rd(rows[i].addr, 32'hFFFFFFFF, rows[i].data);
      end
      $display("register rows done");
      for (int i = 0; i < 5; i++) begin
         for (int b = 0; b < 6; b++) begin
            if (evMask[i][b]) begin
               @(posedge clk) epEvt[i] <= upi_ep_evt_t'(6'h01 << b);
               @(posedge clk) epEvt[i] <= '0;
               rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h1 << i);
               check(irq, 1'b1);
               wr(ADDR_INTERRUPT_PENDING, 32'h0);
               rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h1 << i);
               wr(ADDR_INTERRUPT_PENDING, 32'h1 << i);
               rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h0);
               check(irq, 1'b0);
            end
         end
         // Flags that do not belong to this endpoint must not raise it
         @(posedge clk) epEvt[i] <= upi_ep_evt_t'(~evMask[i]);
         @(posedge clk) epEvt[i] <= '0;
         rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h0);
      end
      wr(ADDR_INTERRUPT_MASK, 32'h00000001);
      @(posedge clk) epEvt[0] <= upi_ep_evt_t'(6'h20);
      @(posedge clk) epEvt[0] <= '0;
      rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h1);
      check(irq, 1'b0);
      wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      wr(ADDR_INTERRUPT_MASK, 32'h0);
      $display("endpoint events done");
      host.setVbus(1'b0);
      repeat (3) @(posedge clk);
      rd(ADDR_POWER_CONTROL, 32'h21, 32'h0);
      host.setVbus(1'b1);
      for (int k = 0; k < 2; k++) begin
         host.drive(upi_bus_t'(5'h11 >> k));
         repeat (3) @(posedge clk);
         host.drive(5'h01);
         rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h100);
         wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      end
      host.drive(5'h05);
      repeat (4) @(posedge clk);
      rd(ADDR_POWER_CONTROL, 32'h8, 32'h8);
      host.drive(5'h01);
      repeat (4) @(posedge clk);
      rd(ADDR_POWER_CONTROL, 32'h8, 32'h0);
      rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h80);
      wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      $display("bus error and reset done");
      host.drive(5'h00);
      repeat (40) @(posedge clk);
      rd(ADDR_POWER_CONTROL, 32'h1FF, 32'h20);
      wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      repeat (36) @(posedge clk);
      rd(ADDR_INTERRUPT_PENDING, 32'h1FF, 32'h20);
      wr(ADDR_POWER_CONTROL, 32'h1);
      repeat (36) @(posedge clk);
      rd(ADDR_POWER_CONTROL, 32'h1FF, 32'h23);
      wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      wr(ADDR_POWER_CONTROL, 32'h5);
      n = 0;
      repeat (45) @(negedge clk) if (resumeDrive === 1'b1) n++;
      check(n, 30);
      host.drive(5'h01);
      rd(ADDR_POWER_CONTROL, 32'h1FF, 32'h21);
      $display("suspend and wake done");
      host.drive(5'h00);
      repeat (40) @(posedge clk);
      wr(ADDR_INTERRUPT_MASK, 32'h3FF);
      wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      host.drive(5'h03);
      repeat (3) @(posedge clk);
      host.drive(5'h01);
      rd(ADDR_INTERRUPT_PENDING, 32'h40, 32'h40);
      rd(ADDR_POWER_CONTROL, 32'h2, 32'h0);
      check(irq, 1'b1);
      wr(ADDR_INTERRUPT_PENDING, 32'h1FF);
      wr(ADDR_INTERRUPT_MASK, 32'h0);
      $display("bus resume done");
      wr(ADDR_POWER_CONTROL, 32'h100);
      repeat (2) @(negedge clk);
      check(clkGate, 1'b1);
      wr(ADDR_POWER_CONTROL, 32'h0);
      repeat (2) @(negedge clk);
      check(clkGate, 1'b1);
      wr(ADDR_POWER_CONTROL, 32'h80);
      repeat (2) @(negedge clk);
      check({clkGate, funcReset}, 2'b01);
      rd(ADDR_INTERRUPT_PENDING, 32'h80, 32'h80);
      wr(ADDR_POWER_CONTROL, 32'h0);
      repeat (2) @(negedge clk);
      check(funcReset, 1'b0);
      wr(ADDR_POWER_CONTROL, 32'h40);
      n = 0;
      repeat (4) @(negedge clk) if (ctrlFifoFlush === 1'b1) n++;
      check(n, 1);
      $display("software reset and flush done");
      printVerdict();
   end
endmodule : tb_top

// file: dv/upi_host_model.sv
`timescale 1ns/1ps
module upi_host_model (
   // Clock
   input  wire logic              clk,
   // Upstream bus
   input  wire logic              resumeDrive,
   output upi_pkg::upi_bus_t      busIn,
   output logic                   vbusIn
);
   import upi_pkg::*;
   // ------------------------------------------------------------
   // Host line state
   // ------------------------------------------------------------
   upi_bus_t drv;
   initial begin
      drv    = 5'h01;
      vbusIn = 1'b1;
   end
   // The device's own resume drive shows on the bus as activity, only while it lasts
   always_comb begin
      busIn           = drv;
      busIn.busActive = drv.busActive | resumeDrive;
   end
   task automatic drive(input upi_bus_t b);
      @(posedge clk);
      drv <= b;
   endtask : drive
   task automatic setVbus(input logic v);
      @(posedge clk);
      vbusIn <= v;
   endtask : setVbus
endmodule : upi_host_model
